// ===== verilog/pss_params.svh
// Constants of the program sequencer core: offsets, fields, vectors, resets
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
`define PSS_OFF_CTRL 4'h0
`define PSS_OFF_STATUS 4'h4
`define PSS_OFF_PC_LOW 4'h8
`define PSS_OFF_ACC 4'hc
`define PSS_CTRL_RUN 0
`define PSS_CTRL_GIE 1
`define PSS_CTRL_IEN_LSB 2
`define PSS_FLG_C 0
`define PSS_FLG_AC 1
`define PSS_FLG_Z 2
`define PSS_FLG_OV 3
`define PSS_VEC_RESET 12'h000
`define PSS_VEC_USB 12'h004
`define PSS_VEC_TMR0 12'h008
`define PSS_VEC_TMR1 12'h00c
`define PSS_STK_DEPTH 8
`define PSS_STK_FULL 4'h8
`define PSS_NOP 15'h6000
`define PSS_ACC_RESET 8'h00
`define PSS_FLG_RESET 4'h0
`endif

// ===== verilog/pss_pkg.sv
// Types shared by the program sequencer core modules
package pss_pkg;
	typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} pss_phase_t;
	typedef enum logic [2:0] {OP_ALU, OP_BRANCH, OP_CALL, OP_RETURN, OP_SKIP, OP_MOVPCL,
		OP_NOP} pss_op_t;
	typedef enum logic [3:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DECADJ, ALU_AND,
		ALU_OR, ALU_XOR, ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC,
		ALU_LD} pss_alu_op_t;
endpackage : pss_pkg

// ===== verilog/pss_stk_if.sv
// Connection between the core and its return stack store
`timescale 1ns/10ps
interface pss_stk_if;
	logic push;
	logic pop;
	logic [11:0] push_data;
	logic [11:0] top;
	logic full;
	modport core (output push, output pop, output push_data, input top, input full);
	modport store (input push, input pop, input push_data, output top, output full);
endinterface : pss_stk_if

// ===== verilog/pss_stack.sv
// Eight-entry return stack with registered top-of-stack read
`timescale 1ns/10ps
`include "pss_params.svh"
module pss_stack import pss_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	pss_stk_if.store stk
);
	logic [11:0] mem [0:`PSS_STK_DEPTH-1];
	logic [2:0] stack_index;
	logic [3:0] depth;

	// Not mapped anywhere: no path from the register bus reaches it
	assign stk.full = (depth == `PSS_STK_FULL);

	always_ff @(posedge pclk) begin
		if (stk.push) begin
			mem[stack_index] <= stk.push_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stk.top <= 12'h000;
		end else begin
			stk.top <= mem[stack_index - 3'h1];
		end
	end

	// Push on a full stack wraps and overwrites the oldest entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_index <= 3'h0;
			depth <= 4'h0;
		end else if (stk.push) begin
			stack_index <= stack_index + 3'h1;
			if (!stk.full) depth <= depth + 4'h1;
		end else if (stk.pop) begin
			stack_index <= stack_index - 3'h1;
			if (depth != 4'h0) depth <= depth - 4'h1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_push_depth: assert property ((stk.push && !stk.full) |=> depth == $past(depth) + 4'h1)
		else $error("push did not deepen the stack");
	a_overflow_wrap: assert property ((stk.push && stk.full) |=> (stk.full && stack_index == $past(stack_index) + 3'h1))
		else $error("overflowing push left the full state");
endmodule : pss_stack

// ===== verilog/pss_alu.sv
// Eight-bit arithmetic and logic unit of the sequencer core
`timescale 1ns/10ps
module pss_alu import pss_pkg::*; (
	input wire pss_alu_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic c_in,
	input wire logic ac_in,
	output logic [7:0] res,
	output logic c_out,
	output logic ac_out,
	output logic ov_out
);
	logic [7:0] bx;
	logic cin;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [8:0] dec;

	// One adder; subtract adds the complement, so carry set means no borrow
	always_comb begin
		bx = b;
		cin = 1'b0;
		case (op)
			ALU_ADC: cin = c_in;
			ALU_SUB: begin
				bx = ~b;
				cin = 1'b1;
			end
			ALU_SBC: begin
				bx = ~b;
				cin = c_in;
			end
			ALU_INC: begin
				bx = 8'h00;
				cin = 1'b1;
			end
			ALU_DEC: bx = 8'hff;
			default: ;
		endcase
		sum = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
		nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
	end

	always_comb begin
		res = sum[7:0];
		c_out = c_in;
		ac_out = ac_in;
		ov_out = 1'b0;
		dec = {1'b0, a};
		case (op)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
				c_out = sum[8];
				ac_out = nib[4];
				ov_out = (a[7] == bx[7]) && (sum[7] != a[7]);
			end
			ALU_INC, ALU_DEC: ov_out = (a[7] == bx[7]) && (sum[7] != a[7]);
			ALU_DECADJ: begin
				if (a[3:0] > 4'h9 || ac_in) dec = dec + 9'h006;
				if (dec[7:4] > 4'h9 || c_in || dec[8]) dec = dec + 9'h060;
				res = dec[7:0];
				c_out = c_in | dec[8];
			end
			ALU_AND: res = a & b;
			ALU_OR: res = a | b;
			ALU_XOR: res = a ^ b;
			ALU_CPL: res = ~a;
			ALU_RR: res = {a[0], a[7:1]};
			ALU_RRC: begin
				res = {c_in, a[7:1]};
				c_out = a[0];
			end
			ALU_RL: res = {a[6:0], a[7]};
			ALU_RLC: begin
				res = {a[6:0], c_in};
				c_out = a[7];
			end
			ALU_LD: res = b;
			default: ;
		endcase
	end
endmodule : pss_alu

// ===== verilog/pss_core.sv
// Program sequencer core: phases, program counter, stack, interrupts, ALU, APB
// Behaviour
// - Four non-overlapping phases form one cycle
// - First phase advances counter and starts fetch
// - Next fetch overlaps current execution
// - Redirecting instructions take two cycles
// - Twelve-bit counter increments unless redirected
// - Low counter byte readable and writable
// - Low-byte write keeps page, adds dummy
// - Taken skip discards prefetch, counter plus two
// - Jump and call load instruction address
// - Fixed reset and interrupt vectors
// - Eight-entry hidden return stack
// - Call/interrupt push, returns pop counter
// - Reset empties the stack
// - Full stack defers interrupt acknowledge
// - Call on full stack still overflows
// - Eight-bit ALU writes result and flags
// - ALU arithmetic, logic, rotate, adjust operations
`timescale 1ns/10ps
`include "pss_params.svh"
module pss_core import pss_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [11:0] imem_addr,
	input wire logic [14:0] imem_rdata,
	input wire logic irq_usb,
	input wire logic irq_tmr0,
	input wire logic irq_tmr1,
	output logic [3:0] phase_clocks
);
	pss_phase_t ph;
	logic ctrl_run;
	logic ctrl_gie;
	logic [2:0] ctrl_ien;
	logic [11:0] pc;
	logic [11:0] ex_pc;
	logic [11:0] fetch_pc;
	logic [14:0] ir;
	logic [14:0] fetch_buf;
	logic ir_dummy;
	logic squash;
	logic [7:0] acc;
	logic [3:0] flg;
	logic [2:0] pend;
	logic pc_low_req;
	logic [7:0] pc_low_val;
	pss_op_t op;
	logic t4;
	logic redirect;
	logic int_take;
	logic acc_wr;
	logic gie_set;
	logic pc_low_take;
	logic apb_wr;
	logic [11:0] next_pc;
	logic [2:0] ack;
	logic [2:0] irq_in;
	logic [2:0] int_req;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_ac;
	logic alu_ov;
	logic [11:0] ir_addr;
	logic [11:0] stk_top;
	logic [3:0] pc_page;

	pss_stk_if stk ();

	function automatic logic [3:0] ph_onehot(input pss_phase_t p);
		ph_onehot = 4'h1 << p;
	endfunction : ph_onehot

	function automatic logic reg_hit(input logic [31:0] a);
		reg_hit = (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
	endfunction : reg_hit

	pss_stack u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.stk(stk)
	);

	pss_alu u_alu (
		.op(pss_alu_op_t'(ir[11:8])),
		.a(acc),
		.b(ir[7:0]),
		.c_in(flg[`PSS_FLG_C]),
		.ac_in(flg[`PSS_FLG_AC]),
		.res(alu_res),
		.c_out(alu_c),
		.ac_out(alu_ac),
		.ov_out(alu_ov)
	);

	assign op = pss_op_t'(ir[14:12]);
	assign ir_addr = ir[11:0];
	assign stk_top = stk.top;
	assign pc_page = pc[11:8];
	assign irq_in = {irq_tmr1, irq_tmr0, irq_usb};
	assign int_req = pend & ctrl_ien;
	assign t4 = ctrl_run && (ph == PH_T4);

	// A stopped core holds its current phase with all phase strobes low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph <= PH_T1;
		end else if (ctrl_run) begin
			ph <= pss_phase_t'(ph + 2'h1);
		end
	end

	assign phase_clocks = ctrl_run ? ph_onehot(ph) : 4'h0;

	// Fetch runs one cycle ahead of execute; a squashed slot becomes a no-op
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= `PSS_VEC_RESET;
			imem_addr <= `PSS_VEC_RESET;
			ir <= `PSS_NOP;
			ir_dummy <= 1'b1;
			squash <= 1'b1;
			ex_pc <= `PSS_VEC_RESET;
			fetch_pc <= `PSS_VEC_RESET;
			fetch_buf <= `PSS_NOP;
		end else if (ctrl_run) begin
			case (ph)
				PH_T1: begin
					imem_addr <= pc;
					pc <= pc + 12'h001;
					ir <= squash ? `PSS_NOP : fetch_buf;
					ir_dummy <= squash;
					ex_pc <= fetch_pc;
					squash <= 1'b0;
				end
				PH_T3: begin
					fetch_buf <= imem_rdata;
					fetch_pc <= imem_addr;
				end
				PH_T4: begin
					if (redirect) begin
						pc <= next_pc;
						squash <= 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// Execute decision, taken in the last phase of each cycle
	always_comb begin
		next_pc = pc;
		redirect = 1'b0;
		int_take = 1'b0;
		acc_wr = 1'b0;
		gie_set = 1'b0;
		pc_low_take = 1'b0;
		ack = 3'h0;
		stk.push = 1'b0;
		stk.pop = 1'b0;
		stk.push_data = ex_pc + 12'h001;
		if (t4 && !ir_dummy) begin
			case (op)
				OP_ALU: acc_wr = 1'b1;
				OP_BRANCH: begin
					redirect = 1'b1;
					next_pc = ir_addr;
				end
				OP_CALL: begin
					redirect = 1'b1;
					next_pc = ir_addr;
					stk.push = 1'b1;
				end
				OP_RETURN: begin
					redirect = 1'b1;
					next_pc = stk.top;
					stk.pop = 1'b1;
					gie_set = ir[0];
				end
				OP_SKIP: redirect = (flg[`PSS_FLG_Z] == ir[0]);
				OP_MOVPCL: begin
					redirect = 1'b1;
					next_pc = {pc[11:8], acc};
				end
				default: ;
			endcase
			if (!redirect && pc_low_req) begin
				redirect = 1'b1;
				pc_low_take = 1'b1;
				next_pc = {pc[11:8], pc_low_val};
			end
			// Holding the request while full keeps the stack from overflowing
			if (!redirect && ctrl_gie && int_req != 3'h0 && !stk.full) begin
				redirect = 1'b1;
				int_take = 1'b1;
				stk.push = 1'b1;
				if (int_req[0]) begin
					next_pc = `PSS_VEC_USB;
					ack = 3'h1;
				end else if (int_req[1]) begin
					next_pc = `PSS_VEC_TMR0;
					ack = 3'h2;
				end else begin
					next_pc = `PSS_VEC_TMR1;
					ack = 3'h4;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= `PSS_ACC_RESET;
			flg <= `PSS_FLG_RESET;
		end else if (acc_wr) begin
			acc <= alu_res;
			flg <= {alu_ov, (alu_res == 8'h00), alu_ac, alu_c};
		end
	end

	// A request arriving with its acknowledge is kept
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pend
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pend[gi] <= 1'b0;
				end else begin
					pend[gi] <= irq_in[gi] | (pend[gi] & ~ack[gi]);
				end
			end
		end
	endgenerate

	// Register bus: zero wait states, error on unmapped words
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_hit(paddr);
	assign apb_wr = psel && penable && pwrite && reg_hit(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_run <= 1'b0;
			ctrl_gie <= 1'b0;
			ctrl_ien <= 3'h0;
		end else begin
			if (apb_wr && paddr[3:0] == `PSS_OFF_CTRL) begin
				ctrl_run <= pwdata[`PSS_CTRL_RUN];
				ctrl_gie <= pwdata[`PSS_CTRL_GIE];
				ctrl_ien <= pwdata[`PSS_CTRL_IEN_LSB +: 3];
			end
			if (int_take) begin
				ctrl_gie <= 1'b0;
			end else if (gie_set) begin
				ctrl_gie <= 1'b1;
			end
		end
	end

	// Bus write to the low byte waits for the next free execute slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_low_req <= 1'b0;
			pc_low_val <= 8'h00;
		end else if (apb_wr && paddr[3:0] == `PSS_OFF_PC_LOW) begin
			pc_low_req <= 1'b1;
			pc_low_val <= pwdata[7:0];
		end else if (pc_low_take) begin
			pc_low_req <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			prdata <= 32'h0;
			if (reg_hit(paddr)) begin
				case (paddr[3:0])
					`PSS_OFF_CTRL: prdata <= {27'h0, ctrl_ien, ctrl_gie, ctrl_run};
					`PSS_OFF_STATUS: prdata <= {25'h0, pend, flg};
					`PSS_OFF_PC_LOW: prdata <= {24'h0, pc[7:0]};
					`PSS_OFF_ACC: prdata <= {24'h0, acc};
					default: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_phase_onehot: assert property ($onehot0(phase_clocks) && (!ctrl_run || phase_clocks == ph_onehot(ph)))
		else $error("phase strobes overlap or mismatch");
	a_phase_order: assert property ((ctrl_run && ph == PH_T4) |=> (ph == PH_T1))
		else $error("phase did not wrap to first");
	a_fetch_addr: assert property ((ctrl_run && ph == PH_T1) |=> (imem_addr == $past(pc)))
		else $error("fetch address not the counter");
	a_pc_step: assert property ((ctrl_run && ph == PH_T1) |=> (pc == $past(pc) + 12'h001))
		else $error("counter did not step by one");
	a_branch_dummy: assert property ((ctrl_run && ph == PH_T1 && squash) |=> (ir_dummy && ir == `PSS_NOP))
		else $error("redirect did not insert dummy");
	a_jump_target: assert property ((t4 && !ir_dummy && op == OP_BRANCH) |=> (pc == $past(ir_addr) && squash))
		else $error("jump target not loaded");
	a_skip_taken: assert property ((t4 && !ir_dummy && op == OP_SKIP && flg[`PSS_FLG_Z] == ir[0]) |=> (squash && $stable(pc)))
		else $error("taken skip mishandled");
	a_skip_plain: assert property ((t4 && !ir_dummy && op == OP_SKIP && flg[`PSS_FLG_Z] != ir[0] && !int_take && !pc_low_req) |=> !squash)
		else $error("untaken skip lost a cycle");
	a_low_page: assert property ((t4 && !ir_dummy && op == OP_MOVPCL) |=> ($stable(pc_page) && pc[7:0] == acc && squash))
		else $error("low byte load left the page");
	a_stack_restore: assert property ((t4 && !ir_dummy && op == OP_RETURN) |=> (pc == $past(stk_top)))
		else $error("return did not restore counter");
	a_usb_vector: assert property ((int_take && int_req[0]) |=> (pc == `PSS_VEC_USB && !ctrl_gie))
		else $error("wrong interrupt vector");
	a_full_defer: assert property ((t4 && stk.full && pend != 3'h0) |-> (!int_take ##1 (pend != 3'h0)))
		else $error("interrupt taken or lost on full stack");

	c_jump: cover property (t4 && !ir_dummy && op == OP_BRANCH);
	c_skip: cover property (t4 && !ir_dummy && op == OP_SKIP && redirect);
	c_irq: cover property (int_take);
	c_defer: cover property (t4 && stk.full && ctrl_gie && int_req != 3'h0);
endmodule : pss_core

// ===== testbench/pss_imem_model.sv
// Program memory model for the sequencer core, prompt or one clock late
`timescale 1ns/10ps
`include "pss_params.svh"
module pss_imem_model #(
	parameter int LAT = 1
) (
	input wire logic pclk,
	input wire logic [11:0] addr,
	output logic [14:0] rdata
);
	logic [14:0] mem [4096];
	logic [14:0] held;

	initial begin
		foreach (mem[i]) mem[i] = `PSS_NOP;
	end

	// Slow mode answers at the latest point the core allows
	always_ff @(posedge pclk) begin
		held <= mem[addr];
	end

	assign rdata = (LAT == 0) ? mem[addr] : held;
endmodule : pss_imem_model

// ===== testbench/testbench.sv
// Self-checking bench of the program sequencer core
`timescale 1ns/10ps
`include "pss_params.svh"
module testbench import pss_pkg::*;;
	typedef struct {
		pss_alu_op_t o0;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] acc;
		logic c;
	} pss_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [11:0] imem_addr;
	logic [14:0] imem_rdata;
	logic [2:0] irq;
	logic [3:0] phase_clocks, pprev;
	bit ok;
	int n_fail, checked;
	pss_row_t rows[16];
	logic [11:0] flow[19];

	pss_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .imem_addr(imem_addr), .imem_rdata(imem_rdata),
		.irq_usb(irq[0]), .irq_tmr0(irq[1]), .irq_tmr1(irq[2]),
		.phase_clocks(phase_clocks));
	pss_imem_model #(.LAT(1)) u_mem (.pclk(pclk), .addr(imem_addr), .rdata(imem_rdata));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", s, e, g);
			n_fail++;
		end
	endtask : chk

	task test_done();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	task rst();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst

	task apb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			test_done();
		end
	endtask : apb

	// One fetch is seen per instruction cycle, in the second phase
	task wf(input logic [11:0] ad, input int n);
		ok = 1'b0;
		while (!ok && n > 0) begin
			@(posedge pclk);
			ok = phase_clocks === 4'b0010 && imem_addr === ad;
			n--;
		end
	endtask : wf

	always @(posedge pclk) begin
		if (presetn && pprev !== 4'b0000 && phase_clocks !== 4'b0000) begin
			chk("phase", {pprev[2:0], pprev[3]}, phase_clocks);
		end
		pprev <= presetn ? phase_clocks : 4'b0000;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		irq = 3'b000;
		n_fail = 0;
		checked = 0;
		rows[0] = '{ALU_ADD, 8'h05, 8'hfb, 8'h00, 1'b1};
		rows[1] = '{ALU_SUB, 8'h00, 8'h10, 8'h11, 1'b0};
		rows[2] = '{ALU_ADD, 8'h05, 8'h07, 8'hfe, 1'b0};
		rows[3] = '{ALU_ADD, 8'h05, 8'h01, 8'h03, 1'b1};
		rows[4] = '{ALU_ADD, 8'h0c, 8'h00, 8'h12, 1'b0};
		rows[5] = '{ALU_ADD, 8'h3c, 8'h0f, 8'h0c, 1'b0};
		rows[6] = '{ALU_ADD, 8'h30, 8'h05, 8'h35, 1'b0};
		rows[7] = '{ALU_ADD, 8'hff, 8'h0f, 8'hf0, 1'b0};
		rows[8] = '{ALU_ADD, 8'h0f, 8'h00, 8'hf0, 1'b0};
		rows[9] = '{ALU_ADD, 8'h81, 8'h00, 8'hc0, 1'b0};
		rows[10] = '{ALU_ADD, 8'h01, 8'h00, 8'h00, 1'b1};
		rows[11] = '{ALU_ADD, 8'h81, 8'h00, 8'h03, 1'b0};
		rows[12] = '{ALU_ADD, 8'h80, 8'h00, 8'h00, 1'b1};
		rows[13] = '{ALU_ADD, 8'hff, 8'h00, 8'h00, 1'b0};
		rows[14] = '{ALU_SUB, 8'h00, 8'h00, 8'hff, 1'b1};
		rows[15] = '{ALU_ADD, 8'h11, 8'h5a, 8'h5a, 1'b0};
		flow = '{12'h000, 12'h001, 12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h015,
			12'h016, 12'h020, 12'h021, 12'h016, 12'h017, 12'h150, 12'h151, 12'h152,
			12'h150, 12'h151, 12'h152};
		rst();
		for (int r = 0; r < 16; r += 4) begin
			apb(1'b0, r, 32'h0);
			chk("reset reg", 32'h0, rd);
		end
		chk("reset fetch", 32'h0, imem_addr);
		apb(1'b1, `PSS_OFF_ACC, 32'hff);
		apb(1'b0, `PSS_OFF_ACC, 32'h0);
		chk("read only", 32'h0, rd);
		apb(1'b0, 32'h2, 32'h0);
		chk("unmapped err", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		$display("register test done");
		// Row index doubles as the second operation code
		foreach (rows[k]) begin
			u_mem.mem[0] = {3'h0, rows[k].o0, rows[k].b0};
			u_mem.mem[1] = {3'h0, 4'(k), rows[k].b1};
			u_mem.mem[2] = 15'h1002;
			rst();
			apb(1'b1, `PSS_OFF_CTRL, 32'h1);
			wf(12'h003, 200);
			apb(1'b0, `PSS_OFF_ACC, 32'h0);
			chk("acc", rows[k].acc, rd);
			apb(1'b0, `PSS_OFF_STATUS, 32'h0);
			// Load sets zero from its result, clears overflow and keeps carry, so its flags go unchecked
			if (k < 15) begin
				chk("zero", rows[k].acc == 8'h00, rd[`PSS_FLG_Z]);
				chk("carry", rows[k].c, rd[`PSS_FLG_C]);
			end
		end
		$display("alu test done");
		u_mem.mem[0] = 15'h1010;
		u_mem.mem[4] = 15'h3001;
		u_mem.mem[8] = 15'h3001;
		u_mem.mem[12] = 15'h3001;
		u_mem.mem[12'h010] = 15'h0005;
		u_mem.mem[12'h011] = 15'h00fb;
		// Taken skip hides a branch that is fetched but must never be executed
		u_mem.mem[12'h012] = 15'h4001;
		u_mem.mem[12'h013] = 15'h1300;
		u_mem.mem[12'h014] = 15'h4000;
		u_mem.mem[12'h015] = 15'h2020;
		u_mem.mem[12'h016] = 15'h1150;
		u_mem.mem[12'h020] = 15'h3000;
		u_mem.mem[12'h151] = 15'h1150;
		rst();
		apb(1'b1, `PSS_OFF_CTRL, 32'h1);
		foreach (flow[i]) begin
			wf(flow[i], 4);
			chk("fetch", 1, ok);
		end
		apb(1'b1, `PSS_OFF_PC_LOW, 32'h30);
		wf(12'h130, 40);
		chk("page jump", 1, ok);
		$display("flow test done");
		apb(1'b1, `PSS_OFF_CTRL, 32'h1f);
		for (int k = 0; k < 3; k++) begin
			irq <= 3'b001 << k;
			@(posedge pclk);
			irq <= 3'b000;
			wf({8'h00, 2'(k + 1), 2'b00}, 60);
			chk("vector", 1, ok);
		end
		apb(1'b0, `PSS_OFF_STATUS, 32'h0);
		chk("pending", 32'h0, rd[6:4]);
		$display("interrupt test done");
		for (int k = 0; k < 8; k++) begin
			u_mem.mem[12'h1c0 + 3 * k] = 15'h21c3 + 15'(3 * k);
			u_mem.mem[12'h1c2 + 3 * k] = 15'h3000;
		end
		u_mem.mem[12'h1d9] = 15'h11d8;
		apb(1'b1, `PSS_OFF_PC_LOW, 32'hc0);
		wf(12'h1d8, 200);
		irq <= 3'b100;
		@(posedge pclk);
		irq <= 3'b000;
		wf(12'h00c, 100);
		chk("deferred", 0, ok);
		apb(1'b0, `PSS_OFF_STATUS, 32'h0);
		chk("kept pending", 1, rd[6]);
		u_mem.mem[12'h1d9] = 15'h3000;
		wf(12'h00c, 100);
		chk("late vector", 1, ok);
		wf(12'h1d7, 60);
		chk("return", 1, ok);
		$display("stack test done");
		test_done();
	end
endmodule : testbench
